// ---- hw/ttfp_nco.sv ----
// phase accumulator that renders one output clock
`timescale 1ns/100ps
module ttfp_nco (
	// clock and reset
	input  wire logic                       CLK,
	input  wire logic                       NRST,
	// control
	input  wire logic                       EN,
	input  wire logic                       SYNC,
	input  wire logic [ttfp_pkg::NCO_W-1:0] INC,
	// clock out
	output wire logic                       CLK_OUT
);

	logic [ttfp_pkg::NCO_W-1:0] acc_reg;
	logic [ttfp_pkg::NCO_W-1:0] acc_next;

	// held at zero when disabled, so the output rests low
	assign acc_next = (!EN || SYNC) ? ttfp_pkg::NCO_RESET : acc_reg + INC;
	assign CLK_OUT  = acc_reg[ttfp_pkg::NCO_W-1];

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			acc_reg <= ttfp_pkg::NCO_RESET;
		else
			acc_reg <= acc_next;
	end

endmodule

// ---- hw/ttfp_pkg.sv ----
// constants, types and helpers for the tdm clock and frame pulse block
package ttfp_pkg;

	// system clock and frame timing
	localparam int CLK_KHZ        = 50000;
	localparam int FRAME_KHZ      = 8;
	localparam int FRAME_CYCLES   = CLK_KHZ / FRAME_KHZ;
	localparam int FCNT_W         = 13;
	localparam int NCO_W          = 32;
	localparam int OFFSET_W       = 8;
	localparam int CHANNEL_SHIFT  = 8;
	localparam int SONET_SEL_BIT  = 10;
	localparam int NUM_CLK_OUT    = 6;
	localparam int NUM_FIXED_FP   = 4;
	localparam int NUM_OFFSET_FP  = 3;

	// output clock rates in kHz
	localparam longint F_1M5_KHZ  = 1544;
	localparam longint F_2M_KHZ   = 2048;
	localparam longint F_4M_KHZ   = 4096;
	localparam longint F_8M_KHZ   = 8192;
	localparam longint F_16M_KHZ  = 16384;
	localparam longint F_32M_KHZ  = 32768;
	localparam longint F_19M_KHZ  = 19440;

	// reset values, last frame count and phase step cap
	localparam logic [FCNT_W-1:0] FCNT_RESET = 13'h0000;
	localparam logic [NCO_W-1:0]  NCO_RESET  = 32'h0000_0000;
	localparam logic              FP_IDLE    = 1'h1;
	localparam logic              CK_IDLE    = 1'h0;
	localparam logic [1:0]        SYNC_RESET = 2'h0;
	localparam logic [FCNT_W-1:0] FCNT_LAST  = 13'(FRAME_CYCLES - 1);
	localparam logic [NCO_W-1:0]  NCO_MAX    = 32'h8000_0000;

	typedef enum logic [1:0] {
		MODE_DIV_SLAVE,
		MODE_MUL_SLAVE,
		MODE_MASTER,
		MODE_MASTER_LOOP
	} ttfp_mode_t;

	typedef enum logic [1:0] {
		RATE_4M,
		RATE_8M,
		RATE_16M,
		RATE_32M
	} ttfp_rate_t;

	typedef struct packed {
		ttfp_mode_t mode;
		logic       slave_pll_enable;
		logic       frame_pulse_polarity;
		logic       frame_pulse_format_select;
		logic       clock_edge_select;
		ttfp_rate_t line_clock_rate;
		ttfp_rate_t clock3_rate;
		logic       clock4_select_2m;
	} ttfp_ctrl_t;

	// phase step per system clock, capped at a half-rate square wave
	function automatic logic [NCO_W-1:0] nco_inc(input longint f_khz);
		longint v;
		v = (f_khz * 64'sh1_0000_0000) / CLK_KHZ;
		if (v > longint'(NCO_MAX))
			v = longint'(NCO_MAX);
		return 32'(v);
	endfunction

	// one output clock period in system cycles, rounded up
	function automatic logic [FCNT_W-1:0] pulse_cycles(input longint f_khz);
		return 13'((CLK_KHZ + f_khz - 1) / f_khz);
	endfunction

	function automatic longint rate_khz(input ttfp_rate_t r);
		longint k;
		k = F_4M_KHZ;
		unique case (r)
			RATE_4M:  k = F_4M_KHZ;
			RATE_8M:  k = F_8M_KHZ;
			RATE_16M: k = F_16M_KHZ;
			RATE_32M: k = F_32M_KHZ;
		endcase
		return k;
	endfunction

	localparam logic [FCNT_W-1:0] OFFSET_PULSE_CYCLES = pulse_cycles(F_4M_KHZ);
	localparam logic [FCNT_W-1:0] SONET_PULSE_CYCLES  = pulse_cycles(F_19M_KHZ);

endpackage

// ---- hw/ttfp_top.sv ----
// tdm timing input qualification, output clocks and frame pulses
`timescale 1ns/100ps
// Functional notes
// - two offset pulses, programmable channel displacement
// - third offset pulse or sonet-aligned pulse
// - sonet pulse only master or slave pll
// - clocks zero to two fixed rates
// - clock three selectable four rates
// - clock four 1.544/2.048, clock five 19.44
// - clocks four, five need master or pll
// - divided slave clocks zero to three not above input
// - input pulse active low unless polarity set
// - format bit selects alternate pulse positioning
// - fixed pulses follow clocks zero to three
// - falling edge boundary unless edge select
module ttfp_top (
	// clock and reset
	input  wire logic                          CLK,
	input  wire logic                          NRST,
	// timing pins
	input  wire logic                          LINE_CLOCK_INPUT,
	input  wire logic                          FRAME_PULSE_INPUT,
	// configuration
	input  wire ttfp_pkg::ttfp_ctrl_t          CONTROL_REGISTER,
	input  wire logic [ttfp_pkg::OFFSET_W-1:0] OFFSET0_CHANNELS,
	input  wire logic [ttfp_pkg::OFFSET_W-1:0] OFFSET1_CHANNELS,
	input  wire logic [10:0]                   THIRD_OFFSET_CONFIG_REGISTER,
	// output clocks
	output wire logic [5:0]                    LINE_CLOCK_OUTPUTS,
	// frame pulses, active low
	output wire logic [3:0]                    FIXED_FRAME_PULSE_OUTPUTS,
	output wire logic [1:0]                    OFFSET_FRAME_PULSE_OUT,
	output wire logic                          THIRD_OFFSET_FRAME_PULSE_OUT
);

	localparam int FW = ttfp_pkg::FCNT_W;
	localparam int OW = ttfp_pkg::OFFSET_W;
	localparam int NW = ttfp_pkg::NCO_W;

	ttfp_pkg::ttfp_ctrl_t ctrl;
	assign ctrl = CONTROL_REGISTER;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and boundary detection

	logic [1:0] ck_sync_reg;
	logic [1:0] fp_sync_reg;
	logic       ck_prev_reg;
	logic       fp_prev_reg;
	logic       armed_reg;
	logic       armed_next;

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			ck_sync_reg <= ttfp_pkg::SYNC_RESET;
			fp_sync_reg <= ttfp_pkg::SYNC_RESET;
			ck_prev_reg <= 1'h0;
			fp_prev_reg <= 1'h0;
			armed_reg   <= 1'h0;
		end
		else
		begin
			ck_sync_reg <= {ck_sync_reg[0], LINE_CLOCK_INPUT};
			fp_sync_reg <= {fp_sync_reg[0], FRAME_PULSE_INPUT};
			ck_prev_reg <= ck_sync_reg[1];
			fp_prev_reg <= fp_sync_reg[1];
			armed_reg   <= armed_next;
		end
	end

	wire ck_s = ck_sync_reg[1];
	wire fp_s = fp_sync_reg[1];

	wire ck_edge = ctrl.clock_edge_select ? (ck_s & ~ck_prev_reg)
	                                      : (~ck_s & ck_prev_reg);
	wire fp_act      = ctrl.frame_pulse_polarity ? fp_s : ~fp_s;
	wire fp_prev_act = ctrl.frame_pulse_polarity ? fp_prev_reg : ~fp_prev_reg;

	wire bnd_centred = ck_edge & fp_act & armed_reg;
	wire bnd_leading = fp_act & ~fp_prev_act;
	wire boundary    = ctrl.frame_pulse_format_select ? bnd_leading
	                                                  : bnd_centred;
	assign armed_next = (ck_edge & ~fp_act) | (armed_reg & ~bnd_centred);

	wire slave   = (ctrl.mode == ttfp_pkg::MODE_DIV_SLAVE) ||
	               (ctrl.mode == ttfp_pkg::MODE_MUL_SLAVE);
	wire master  = !slave;
	wire pll_ok  = master | ctrl.slave_pll_enable;
	// loopback master never looks at the pulse input
	wire resync  = slave & boundary;

	////////////////////////////////////////////////////////////////////
	// frame counter

	logic [FW-1:0] fcnt_reg;
	logic [FW-1:0] fcnt_next;

	assign fcnt_next = (resync || fcnt_reg == ttfp_pkg::FCNT_LAST)
	                   ? ttfp_pkg::FCNT_RESET : fcnt_reg + 13'h0001;

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
			fcnt_reg <= ttfp_pkg::FCNT_RESET;
		else
			fcnt_reg <= fcnt_next;
	end

	wire frame_start = (fcnt_next == ttfp_pkg::FCNT_RESET);

	////////////////////////////////////////////////////////////////////
	// output clocks

	ttfp_pkg::ttfp_rate_t ck_rate [0:3];
	assign ck_rate[0] = ttfp_pkg::RATE_4M;
	assign ck_rate[1] = ttfp_pkg::RATE_8M;
	assign ck_rate[2] = ttfp_pkg::RATE_16M;
	assign ck_rate[3] = ctrl.clock3_rate;

	logic [NW-1:0] ck_inc [0:5];
	logic [5:0]    ck_en;

	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_low_clk
			assign ck_inc[i] = ttfp_pkg::nco_inc(ttfp_pkg::rate_khz(ck_rate[i]));
			// divided slave caps at input rate
			assign ck_en[i]  = !((ctrl.mode == ttfp_pkg::MODE_DIV_SLAVE) &&
			                   (ck_rate[i] > ctrl.line_clock_rate));
		end
	endgenerate

	// clock four choice, clock five fixed
	assign ck_inc[4] = ctrl.clock4_select_2m
	                   ? ttfp_pkg::nco_inc(ttfp_pkg::F_2M_KHZ)
	                   : ttfp_pkg::nco_inc(ttfp_pkg::F_1M5_KHZ);
	assign ck_inc[5] = ttfp_pkg::nco_inc(ttfp_pkg::F_19M_KHZ);
	assign ck_en[4]  = pll_ok;
	assign ck_en[5]  = pll_ok;

	generate
		for (i = 0; i < ttfp_pkg::NUM_CLK_OUT; i++)
		begin : g_nco
			ttfp_nco u_nco (
				.CLK     (CLK),
				.NRST    (NRST),
				.EN      (ck_en[i]),
				.SYNC    (frame_start),
				.INC     (ck_inc[i]),
				.CLK_OUT (LINE_CLOCK_OUTPUTS[i])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// frame pulses

	logic [3:0] fixed_act;
	logic [2:0] off_act;

	generate
		for (i = 0; i < ttfp_pkg::NUM_FIXED_FP; i++)
		begin : g_fixed
			// one clock period at the boundary
			assign fixed_act[i] = ck_en[i] && (fcnt_reg <
			       ttfp_pkg::pulse_cycles(ttfp_pkg::rate_khz(ck_rate[i])));
		end
	endgenerate

	logic [OW-1:0] off_ch [0:2];
	assign off_ch[0] = OFFSET0_CHANNELS;
	assign off_ch[1] = OFFSET1_CHANNELS;
	assign off_ch[2] = THIRD_OFFSET_CONFIG_REGISTER[OW-1:0];

	generate
		for (i = 0; i < ttfp_pkg::NUM_OFFSET_FP; i++)
		begin : g_offset
			wire [OW+FW-1:0] prod  = off_ch[i] * 13'(ttfp_pkg::FRAME_CYCLES);
			wire [FW-1:0]    start = prod[OW+FW-1:ttfp_pkg::CHANNEL_SHIFT];
			wire [FW:0]      stop  = {1'h0, start} +
			                         {1'h0, ttfp_pkg::OFFSET_PULSE_CYCLES};
			assign off_act[i] = (fcnt_reg >= start) &&
			                    ({1'h0, fcnt_reg} < stop);
		end
	endgenerate

	wire sonet_sel = THIRD_OFFSET_CONFIG_REGISTER[ttfp_pkg::SONET_SEL_BIT];
	wire sonet_act = pll_ok && (fcnt_reg < ttfp_pkg::SONET_PULSE_CYCLES);
	// select bit swaps in sonet pulse
	wire third_act = sonet_sel ? sonet_act : off_act[2];

	logic [3:0] fixed_fp_reg;
	logic [1:0] off_fp_reg;
	logic       third_fp_reg;

	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			fixed_fp_reg <= {4{ttfp_pkg::FP_IDLE}};
			off_fp_reg   <= {2{ttfp_pkg::FP_IDLE}};
			third_fp_reg <= ttfp_pkg::FP_IDLE;
		end
		else
		begin
			fixed_fp_reg <= ~fixed_act;
			off_fp_reg   <= ~off_act[1:0];
			third_fp_reg <= ~third_act;
		end
	end

	assign FIXED_FRAME_PULSE_OUTPUTS    = fixed_fp_reg;
	assign OFFSET_FRAME_PULSE_OUT       = off_fp_reg;
	assign THIRD_OFFSET_FRAME_PULSE_OUT = third_fp_reg;

endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the tdm timing block
`timescale 1ns/100ps
module testbench;
	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	logic                 act = 1'b0;
	logic                 hold = 1'b0;
	ttfp_pkg::ttfp_ctrl_t ctrl = '0;
	logic [10:0]          third = 11'h000;
	wire logic            lck, frame_pulse_input, tfp;
	wire logic [5:0]      ck;
	wire logic [3:0]      fx;
	wire logic [1:0]      ofp;
	wire logic [13:0]     pl = {frame_pulse_input != act, tfp, ofp, fx, ck};
	logic [13:0]          pv;
	int                   n[14];
	int                   fails = 0;
	int                   n_compared = 0;
	always #10 clk = ~clk;
	always @(negedge clk) pv <= pl;
	ttfp_backplane bp (.act_high(act), .hold(hold), .line_clk(lck),
		.frame_pulse(frame_pulse_input));
	ttfp_top dut (.CLK(clk), .NRST(nrst), .LINE_CLOCK_INPUT(lck),
		.FRAME_PULSE_INPUT(frame_pulse_input), .CONTROL_REGISTER(ctrl),
		.OFFSET0_CHANNELS(8'h10), .OFFSET1_CHANNELS(8'h80),
		.THIRD_OFFSET_CONFIG_REGISTER(third), .LINE_CLOCK_OUTPUTS(ck),
		.FIXED_FRAME_PULSE_OUTPUTS(fx), .OFFSET_FRAME_PULSE_OUT(ofp),
		.THIRD_OFFSET_FRAME_PULSE_OUT(tfp));
	////////////////////////////////////////////////////////////////////////
	task check(input string what, input int seen, input int exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task conclude;
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task setup(input ttfp_pkg::ttfp_ctrl_t c, input logic [10:0] t);
		@(posedge clk);
		nrst <= 1'b0;
		ctrl <= c;
		third <= t;
		act <= c.frame_pulse_polarity;
		hold <= c.mode == ttfp_pkg::MODE_MASTER_LOOP;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
	endtask
	task fall(input int i, output int k);
		k = 0;
		do
		begin
			@(negedge clk);
			k++;
		end
		while (!(pv[i] && !pl[i]) && k < 14000);
	endtask
	task low_len(input int i, output int k);
		int j;
		fall(i, j);
		k = 0;
		while (!pl[i] && k < 9000)
		begin
			k++;
			@(negedge clk);
		end
	endtask
	// rising edges of every bit over one frame
	task rises;
		n = '{default: 0};
		repeat (6250)
		begin
			@(negedge clk);
			for (int b = 0; b < 14; b++)
				n[b] += int'(!pv[b] && pl[b]);
		end
	endtask
	task rate(input int i, input int e);
		check("clock rises",
			(e > 0 && n[i] > 0 && n[i] >= e - 1 && n[i] <= e + 1)
			? e : n[i], e);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		ttfp_pkg::ttfp_ctrl_t c;
		int k, g, r;
		for (r = 0; r < 4; r++)
		begin
			c = '0;
			c.mode = ttfp_pkg::MODE_MASTER;
			// last pass runs loopback master, pin held
			if (r == 3)
				c.mode = ttfp_pkg::MODE_MASTER_LOOP;
			c.clock3_rate = ttfp_pkg::ttfp_rate_t'(r);
			c.clock4_select_2m = r[0];
			setup(c, {r[0], 10'h0C0});
			if (r < 2)
			begin
				fall(6, k);
				fall(10, g);
				check("offset0 delay", g, (16 * 6250) >> 8);
				fall(11, k);
				g += k;
				check("offset1 delay", g, (128 * 6250) >> 8);
				if (r[0])
					low_len(12, k);
				else
					fall(12, k);
				check("third pulse", r[0] ? k : g + k, r[0] ? 3 : 4687);
				low_len(6, k);
				check("fixed0 width", k, 13);
			end
			rises;
			rate(0, 512);
			rate(1, 1024);
			rate(2, 2048);
			rate(3, r < 3 ? 512 << r : 3125);
			rate(4, r[0] ? 256 : 193);
			rate(5, 2430);
			rate(7, 1);
			rate(9, 1);
		end
		for (k = 0; k < 2; k++)
		begin
			c = '0;
			c.clock3_rate = ttfp_pkg::RATE_8M;
			c.slave_pll_enable = k[0];
			setup(c, 11'h400);
			rises;
			rate(1, 0);
			rate(3, 0);
			rate(7, 0);
			rate(9, 0);
			rate(4, k * 193);
			rate(5, k * 2430);
			rate(12, k);
		end
		for (r = 0; r < 4; r++)
		begin
			c = '0;
			c.frame_pulse_polarity = r == 1;
			c.frame_pulse_format_select = r == 2;
			c.clock_edge_select = r >= 2;
			setup(c, 11'h000);
			fall(13, g);
			fall(6, g);
			if (r < 2)
				check("frame lock", g > 8 && g <= 16, 1);
			else if (r == 2)
				check("leading lock", g <= 8, 1);
			else
				check("rising lock", g <= 8, 1);
		end
		conclude;
	end
	initial
	begin
		// tests need about 82k cycles; limit at 95k
		#1900000;
		fails++;
		conclude;
	end
endmodule
bind ttfp_top ttfp_asserts chk (.CLK(CLK), .NRST(NRST),
	.CONTROL_REGISTER(CONTROL_REGISTER),
	.THIRD_OFFSET_CONFIG_REGISTER(THIRD_OFFSET_CONFIG_REGISTER),
	.LINE_CLOCK_OUTPUTS(LINE_CLOCK_OUTPUTS),
	.FIXED_FRAME_PULSE_OUTPUTS(FIXED_FRAME_PULSE_OUTPUTS),
	.OFFSET_FRAME_PULSE_OUT(OFFSET_FRAME_PULSE_OUT),
	.THIRD_OFFSET_FRAME_PULSE_OUT(THIRD_OFFSET_FRAME_PULSE_OUT));

// ---- testbench/ttfp_asserts.sv ----
// port checks for the tdm timing block
`timescale 1ns/100ps
module ttfp_asserts (
	// clock and reset
	input wire logic                 CLK,
	input wire logic                 NRST,
	// configuration
	input wire ttfp_pkg::ttfp_ctrl_t CONTROL_REGISTER,
	input wire logic [10:0]          THIRD_OFFSET_CONFIG_REGISTER,
	// outputs
	input wire logic [5:0]           LINE_CLOCK_OUTPUTS,
	input wire logic [3:0]           FIXED_FRAME_PULSE_OUTPUTS,
	input wire logic [1:0]           OFFSET_FRAME_PULSE_OUT,
	input wire logic                 THIRD_OFFSET_FRAME_PULSE_OUT
);
	wire logic       mst = CONTROL_REGISTER.mode >= ttfp_pkg::MODE_MASTER;
	wire logic       ext = mst | CONTROL_REGISTER.slave_pll_enable;
	wire logic       sel =
		THIRD_OFFSET_CONFIG_REGISTER[ttfp_pkg::SONET_SEL_BIT];
	wire logic [5:0] ck  = LINE_CLOCK_OUTPUTS;
	wire logic [3:0] fx  = FIXED_FRAME_PULSE_OUTPUTS;
	wire logic       of0 = OFFSET_FRAME_PULSE_OUT[0];
	wire logic       sp  = THIRD_OFFSET_FRAME_PULSE_OUT;
	wire logic       cap = CONTROL_REGISTER.mode == ttfp_pkg::MODE_DIV_SLAVE
		&& CONTROL_REGISTER.clock3_rate > CONTROL_REGISTER.line_clock_rate;
	logic [12:0]     since_reg;
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	////////////////////////////////////////////////////////////////////////
	// cycles since last offset pulse start
	always_ff @(posedge CLK or negedge NRST)
		if (!NRST)
			since_reg <= 13'h1FFF;
		else if ($fell(of0))
			since_reg <= 13'h0000;
		else if (since_reg != 13'h1FFF)
			since_reg <= since_reg + 13'h0001;
	sequence off_low;
		!of0 [*8] ##1 !of0 [*5] ##1 of0;
	endsequence
	sequence fx2_low;
		!fx[2] [*4] ##1 fx[2];
	endsequence
	sequence sp_low;
		!sp [*3] ##1 sp;
	endsequence
	////////////////////////////////////////////////////////////////////////
	a_clk4_gated: assert property (!ext |-> !ck[4])
		else $error("clock four runs while gated");
	a_clk5_gated: assert property (!ext |-> !ck[5])
		else $error("clock five runs while gated");
	a_sonet_gated: assert property (!ext && sel |-> sp)
		else $error("sonet pulse while gated");
	a_div_cap: assert property (cap |-> !ck[3] && fx[3])
		else $error("clock three above input clock");
	a_fixed2_width: assert property (mst && $fell(fx[2]) |-> fx2_low)
		else $error("fixed pulse two width wrong");
	a_frame_align: assert property ($fell(fx[0]) |-> !ck[0])
		else $error("fixed pulse zero not on clock low");
	a_offset_width: assert property (mst && $fell(of0) |-> off_low)
		else $error("offset pulse width wrong");
	a_offset_period: assert property (mst && $fell(of0) |->
		since_reg == 13'h1869 || since_reg == 13'h1FFF)
		else $error("offset pulse not once per frame");
	a_sonet_width: assert property (mst && sel && $fell(sp) |-> sp_low)
		else $error("sonet pulse width wrong");
endmodule

// ---- testbench/ttfp_backplane.sv ----
// backplane source of line clock and frame pulse
`timescale 1ns/100ps
module ttfp_backplane (
	// active level of the pulse
	input  wire logic act_high,
	// pulse pin held idle for loopback master
	input  wire logic hold,
	// timing pins
	output logic      line_clk,
	output logic      frame_pulse
);
	int i;
	// 4 MHz clock, 244 ns pulse
	// no 16 Mbps streams, wide pulse allowed
	// static pulse level while hold is set
	initial
	begin
		line_clk = 1'b0;
		forever
			for (i = 0; i < 512; i++)
			begin
				line_clk = 1'b1;
				frame_pulse = act_high ^ (hold || i != 0);
				#122.1 line_clk = 1'b0;
				#122.1;
			end
	end
endmodule
